/* File: src/opc_pkg.sv */
// constants and types of the octal psram command front end
// assumes one 200 MHz clock; the link is sampled through per-edge strobes
package opc_pkg;

  localparam int ROW_W   = 13;
  localparam int COL_W   = 10;
  localparam int WADDR_W = ROW_W + COL_W - 1;
  localparam int FIFO_W  = WADDR_W + 18;

  localparam logic [2:0] HDR_LAST = 3'h5;

  localparam logic [7:0] CMD_RD_CONT = 8'ha0;
  localparam logic [7:0] CMD_RD_WRAP = 8'h80;
  localparam logic [7:0] CMD_WR_CONT = 8'h20;
  localparam logic [7:0] CMD_WR_WRAP = 8'h00;
  localparam logic [7:0] CMD_RRD_A   = 8'hc0;
  localparam logic [7:0] CMD_RRD_B   = 8'he0;
  localparam logic [7:0] CMD_RWR     = 8'h60;
  localparam logic [7:0] CMD_TRAIN   = 8'hf0;
  localparam logic [7:0] CMD_TAIL    = 8'h00;

  localparam logic [31:0] SEL_ID  = 32'h00000000;
  localparam logic [31:0] SEL_CFG = 32'h00040000;
  localparam logic [31:0] SEL_ECC = 32'h01000003;

  localparam int CFG_LAT_LSB   = 4;
  localparam int CFG_FIXED_BIT = 3;
  localparam int CFG_WRAP_LSB  = 0;
  localparam int ECC_CLR_BIT   = 9;

  localparam logic [15:0] CFG_RESET = 16'h0030;
  localparam logic [15:0] ECC_RESET = 16'h0000;

  localparam logic [WADDR_W-1:0] WRAP_MIN_WORDS = 22'h000008;

  localparam logic [15:0] TRN_A_OTHER = 16'h349a;
  localparam logic [15:0] TRN_A_LINE3 = 16'h3514;
  localparam logic [15:0] TRN_B_ALL   = 16'h5555;

  typedef enum logic [2:0] {
    OPC_ST_IDLE = 3'h0,
    OPC_ST_HDR  = 3'h1,
    OPC_ST_LAT  = 3'h3,
    OPC_ST_DATA = 3'h2,
    OPC_ST_WAIT = 3'h6
  } opc_state_t;

  typedef enum logic [2:0] {
    OPC_OP_NONE = 3'h0,
    OPC_OP_RD   = 3'h1,
    OPC_OP_WR   = 3'h2,
    OPC_OP_RRD  = 3'h3,
    OPC_OP_RWR  = 3'h4,
    OPC_OP_TRN  = 3'h5
  } opc_op_t;

  typedef enum logic [1:0] {
    OPC_REG_ID   = 2'h0,
    OPC_REG_CFG  = 2'h1,
    OPC_REG_ECC  = 2'h2,
    OPC_REG_NONE = 2'h3
  } opc_reg_t;

endpackage

/* File: src/opc_stream_if.sv */
// valid/ready word stream between the front end and its write buffer
// assumes both ends share i_clk
`timescale 1ns/1ps
interface opc_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: src/opc_fifo.sv */
// synchronous first-in first-out buffer with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/1ps
module opc_fifo #(
  parameter int W     = 40,
  parameter int DEPTH = 32
) (
  input wire logic   i_clk,
  input wire logic   i_reset,
  opc_stream_if.snk  in_s,
  opc_stream_if.src  out_s
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         full;
  logic         empty;

  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty       = (wr_q == rd_q);
  assign in_s.ready  = ~full;
  assign out_s.valid = ~empty;
  assign out_s.data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (in_s.valid && !full) begin
      mem_q[wr_q[AW-1:0]] <= in_s.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_s.valid && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_s.ready && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

/* File: src/opc_array.sv */
// word array with two byte lanes, one write port and a registered read port
// assumes lane contents already carry their check bits
`timescale 1ns/1ps
module opc_array #(
  parameter int AW = 22,
  parameter int DW = 32
) (
  input  wire logic          i_clk,
  input  wire logic [1:0]    i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_re,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  localparam int LW = DW / 2;

  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge i_clk) begin
    for (int g = 0; g < 2; g++) begin
      if (i_we[g]) begin
        mem_q[i_waddr][g*LW +: LW] <= i_wdata[g*LW +: LW];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_re) begin
      o_rdata <= mem_q[i_raddr];
    end
  end
endmodule

/* File: src/opc_frontend.sv */
// command and address front end of an octal serial psram with on-chip ecc
// assumes link pins sampled on i_clk; i_link_edge marks each serial clock edge
//
// Function
// - falling select_n starts a new header
// - hard_init_n low resets, pins released
// - header: command, row, column clocks
// - sample command/address centre-aligned on edges
// - row 13 bits: 12..8 then 7..0
// - column 10 bits: 9..4 then 3..0
// - data moves only in whole words
// - a0/80 then 00: continuous/wrapped read
// - 20/00 then 00: continuous/wrapped write
// - c0/e0 register read, 60 register write
// - f0 00 returns pattern chosen by col_bit_zero
// - strobe_mask shows refresh collision during header
// - strobe_mask strobes read bytes
// - strobe_mask is host input during writes
// - strobe_mask high masks a write byte
// - ecc on nibbles: correct one, detect two
// - ecc events reported on ecc_event_flag
// - flag holds until ecc register bit 9
// - wrap lengths 16/32/64/128 in word order
// - continuous read stops at array end
// - continuous write wraps to address zero
// - variable and fixed latency modes
// - fixed latency always uses doubled count
// - array of 8M bytes, refresh hidden
`timescale 1ns/1ps
module opc_frontend #(
  parameter logic [15:0] ID_VALUE   = 16'h5a5a,  // arbitrary identification value
  parameter int          FIFO_DEPTH = 32
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_hard_init_n,
  input  wire logic       i_select_n,
  input  wire logic       i_link_edge,
  input  wire logic [7:0] i_octal_io,
  output logic      [7:0] o_octal_io,
  output logic            o_octal_io_oe_n,
  input  wire logic       i_strobe_mask,
  output logic            o_strobe_mask,
  output logic            o_strobe_mask_oe_n,
  input  wire logic       i_refresh_pending,
  input  wire logic [1:0] i_ecc_inject,
  output logic            o_ecc_event_flag,
  output logic            o_write_overrun
);
  localparam int AW = opc_pkg::WADDR_W;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic                 rst;
  logic                 sel_q;
  logic                 edge_ok;
  opc_pkg::opc_state_t  state_q;
  opc_pkg::opc_op_t     op_q;
  opc_pkg::opc_op_t     op_dec;
  logic [2:0]           hcnt_q;
  logic [5:0]           lat_q;
  logic [5:0]           lat_edges;
  logic                 phase_q;
  logic                 wrap_q;
  logic                 refr_q;
  logic [7:0]           cmd_q;
  logic [31:0]          araw_q;
  logic [31:0]          hdr_full;
  logic [AW-1:0]        waddr_q;
  logic                 trn_sel_q;
  logic [3:0]           trn_q;
  logic                 rd_req_q;
  logic                 rvalid_q;
  logic [15:0]          rd_word_q;
  logic [15:0]          rd_fix;
  logic                 rd_err;
  logic [31:0]          mem_rdata;
  logic [31:0]          mem_wdata;
  logic [1:0]           mem_we;
  logic [7:0]           lo_q;
  logic                 mlo_q;
  logic [7:0]           reg_hi_q;
  logic [15:0]          cfg_q;
  logic [15:0]          ecc_q;
  logic [15:0]          regval;
  logic                 ecc_clr;
  logic [7:0]           out_byte;
  logic                 wr_push;
  logic                 is_read_op;

  opc_stream_if #(.W(opc_pkg::FIFO_W)) wr_in ();
  opc_stream_if #(.W(opc_pkg::FIFO_W)) wr_out ();

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic opc_pkg::opc_op_t dec_cmd(input logic [7:0] c0, input logic [7:0] c1);
    dec_cmd = opc_pkg::OPC_OP_NONE;
    if (c1 == opc_pkg::CMD_TAIL) begin
      case (c0)
        opc_pkg::CMD_RD_CONT, opc_pkg::CMD_RD_WRAP: dec_cmd = opc_pkg::OPC_OP_RD;
        opc_pkg::CMD_WR_CONT, opc_pkg::CMD_WR_WRAP: dec_cmd = opc_pkg::OPC_OP_WR;
        opc_pkg::CMD_RRD_A, opc_pkg::CMD_RRD_B:     dec_cmd = opc_pkg::OPC_OP_RRD;
        opc_pkg::CMD_RWR:                           dec_cmd = opc_pkg::OPC_OP_RWR;
        opc_pkg::CMD_TRAIN:                         dec_cmd = opc_pkg::OPC_OP_TRN;
        default:                                    dec_cmd = opc_pkg::OPC_OP_NONE;
      endcase
    end
  endfunction

  function automatic opc_pkg::opc_reg_t reg_sel(input logic [31:0] a);
    if (a == opc_pkg::SEL_ID) begin
      reg_sel = opc_pkg::OPC_REG_ID;
    end else if (a == opc_pkg::SEL_CFG) begin
      reg_sel = opc_pkg::OPC_REG_CFG;
    end else if (a == opc_pkg::SEL_ECC) begin
      reg_sel = opc_pkg::OPC_REG_ECC;
    end else begin
      reg_sel = opc_pkg::OPC_REG_NONE;
    end
  endfunction

  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a, input logic wrap,
                                               input logic [1:0] wl, input logic rd);
    logic [AW-1:0] m;
    m = (opc_pkg::WRAP_MIN_WORDS << wl) - 22'h000001;
    if (wrap) begin
      next_addr = (a & ~m) | ((a + 22'h000001) & m);
    end else if (rd && (&a)) begin
      next_addr = a;
    end else begin
      next_addr = a + 22'h000001;
    end
  endfunction

  function automatic logic [3:0] ecc_enc(input logic [3:0] d);
    logic p1;
    logic p2;
    logic p3;
    p1 = d[0] ^ d[1] ^ d[3];
    p2 = d[0] ^ d[2] ^ d[3];
    p3 = d[1] ^ d[2] ^ d[3];
    ecc_enc = {^{d, p1, p2, p3}, p3, p2, p1};
  endfunction

  function automatic logic [4:0] ecc_dec(input logic [3:0] d, input logic [3:0] c);
    logic [2:0] s;
    logic       tot;
    logic [3:0] f;
    s   = {c[2] ^ d[1] ^ d[2] ^ d[3], c[1] ^ d[0] ^ d[2] ^ d[3], c[0] ^ d[0] ^ d[1] ^ d[3]};
    tot = ^{d, c};
    f   = d;
    if (tot) begin
      f[0] = d[0] ^ (s == 3'h3);
      f[1] = d[1] ^ (s == 3'h5);
      f[2] = d[2] ^ (s == 3'h6);
      f[3] = d[3] ^ (s == 3'h7);
    end
    ecc_dec = {(s != 3'h0) | tot, f};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  assign rst        = i_reset | ~i_hard_init_n;
  assign edge_ok    = i_link_edge & ~i_select_n;
  assign hdr_full   = {araw_q[23:0], i_octal_io};
  assign op_dec     = dec_cmd(cmd_q, i_octal_io);
  assign lat_edges  = (cfg_q[opc_pkg::CFG_FIXED_BIT] | refr_q | i_refresh_pending) ?
                      {cfg_q[opc_pkg::CFG_LAT_LSB +: 4], 2'h0} :
                      {1'b0, cfg_q[opc_pkg::CFG_LAT_LSB +: 4], 1'b0};
  assign is_read_op = (op_q == opc_pkg::OPC_OP_RD) || (op_q == opc_pkg::OPC_OP_RRD) ||
                      (op_q == opc_pkg::OPC_OP_TRN);

  always_ff @(posedge i_clk) begin
    if (rst) begin
      sel_q <= 1'b1;
    end else begin
      sel_q <= i_select_n;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      state_q <= opc_pkg::OPC_ST_IDLE;
      op_q    <= opc_pkg::OPC_OP_NONE;
      hcnt_q  <= 3'h0;
      lat_q   <= 6'h00;
      phase_q <= 1'b0;
      wrap_q  <= 1'b0;
    end else if (i_select_n) begin
      state_q <= opc_pkg::OPC_ST_IDLE;
    end else begin
      unique case (state_q)
        opc_pkg::OPC_ST_IDLE: if (sel_q) begin
          state_q <= opc_pkg::OPC_ST_HDR;
          hcnt_q  <= 3'h0;
          phase_q <= 1'b0;
        end
        opc_pkg::OPC_ST_HDR: if (i_link_edge) begin
          hcnt_q <= hcnt_q + 3'h1;
          if (hcnt_q == 3'h1) begin
            op_q   <= op_dec;
            wrap_q <= (cmd_q == opc_pkg::CMD_RD_WRAP) || (cmd_q == opc_pkg::CMD_WR_WRAP);
            if (op_dec == opc_pkg::OPC_OP_NONE) begin
              state_q <= opc_pkg::OPC_ST_WAIT;
            end
          end
          if (hcnt_q == opc_pkg::HDR_LAST) begin
            if (op_q == opc_pkg::OPC_OP_RWR || lat_edges == 6'h00) begin
              state_q <= opc_pkg::OPC_ST_DATA;
            end else begin
              state_q <= opc_pkg::OPC_ST_LAT;
              lat_q   <= lat_edges;
            end
          end
        end
        opc_pkg::OPC_ST_LAT: if (i_link_edge) begin
          lat_q <= lat_q - 6'h01;
          if (lat_q == 6'h01) begin
            state_q <= opc_pkg::OPC_ST_DATA;
          end
        end
        opc_pkg::OPC_ST_DATA: if (i_link_edge) begin
          phase_q <= ~phase_q;
          if (op_q == opc_pkg::OPC_OP_RWR && phase_q) begin
            state_q <= opc_pkg::OPC_ST_WAIT;
          end
        end
        opc_pkg::OPC_ST_WAIT: ;
        default: state_q <= opc_pkg::OPC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst || state_q == opc_pkg::OPC_ST_IDLE) begin
      refr_q <= 1'b0;
    end else if (state_q == opc_pkg::OPC_ST_HDR) begin
      refr_q <= refr_q | i_refresh_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // header capture and addressing

  always_ff @(posedge i_clk) begin
    if (rst) begin
      cmd_q  <= 8'h00;
      araw_q <= 32'h00000000;
    end else if (state_q == opc_pkg::OPC_ST_HDR && edge_ok) begin
      if (hcnt_q == 3'h0) begin
        cmd_q <= i_octal_io;
      end
      if (hcnt_q >= 3'h2) begin
        araw_q <= hdr_full;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      waddr_q   <= '0;
      trn_sel_q <= 1'b0;
    end else if (state_q == opc_pkg::OPC_ST_HDR && edge_ok && hcnt_q == opc_pkg::HDR_LAST) begin
      waddr_q   <= {hdr_full[28:24], hdr_full[23:16], hdr_full[15:10], hdr_full[3:1]};
      trn_sel_q <= hdr_full[0];
    end else if (state_q == opc_pkg::OPC_ST_DATA && edge_ok && phase_q &&
                 (op_q == opc_pkg::OPC_OP_RD || op_q == opc_pkg::OPC_OP_WR)) begin
      waddr_q <= next_addr(waddr_q, wrap_q, cfg_q[opc_pkg::CFG_WRAP_LSB +: 2], op_q == opc_pkg::OPC_OP_RD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_ff @(posedge i_clk) begin
    if (rst) begin
      rd_req_q <= 1'b0;
      rvalid_q <= 1'b0;
    end else begin
      rd_req_q <= edge_ok && op_q == opc_pkg::OPC_OP_RD &&
                  ((state_q == opc_pkg::OPC_ST_HDR && hcnt_q == opc_pkg::HDR_LAST && lat_edges == 6'h00) ||
                   (state_q == opc_pkg::OPC_ST_LAT && lat_q == 6'h01) ||
                   (state_q == opc_pkg::OPC_ST_DATA && phase_q));
      rvalid_q <= rd_req_q;
    end
  end

  always_comb begin
    logic [4:0] r;
    r      = 5'h00;
    rd_err = 1'b0;
    rd_fix = 16'h0000;
    for (int k = 0; k < 4; k++) begin
      r                 = ecc_dec(mem_rdata[(k/2)*16 + (k%2)*4 +: 4], mem_rdata[(k/2)*16 + 8 + (k%2)*4 +: 4]);
      rd_fix[k*4 +: 4]  = r[3:0];
      rd_err            = rd_err | r[4];
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      rd_word_q <= 16'h0000;
    end else if (rvalid_q) begin
      rd_word_q <= rd_fix;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst || state_q == opc_pkg::OPC_ST_IDLE) begin
      trn_q <= 4'h0;
    end else if (state_q == opc_pkg::OPC_ST_DATA && edge_ok) begin
      trn_q <= trn_q + 4'h1;
    end
  end

  always_comb begin
    logic o;
    logic t3;
    o  = trn_sel_q ? opc_pkg::TRN_B_ALL[4'hf - trn_q] : opc_pkg::TRN_A_OTHER[4'hf - trn_q];
    t3 = trn_sel_q ? opc_pkg::TRN_B_ALL[4'hf - trn_q] : opc_pkg::TRN_A_LINE3[4'hf - trn_q];
    unique case (op_q)
      opc_pkg::OPC_OP_RD:  out_byte = phase_q ? rd_word_q[15:8] : rd_word_q[7:0];
      opc_pkg::OPC_OP_RRD: out_byte = phase_q ? regval[7:0] : regval[15:8];
      opc_pkg::OPC_OP_TRN: out_byte = {{4{o}}, t3, {3{o}}};
      default:             out_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins

  always_ff @(posedge i_clk) begin
    if (rst || i_select_n) begin
      o_octal_io         <= 8'h00;
      o_octal_io_oe_n    <= 1'b1;
      o_strobe_mask      <= 1'b0;
      o_strobe_mask_oe_n <= 1'b1;
    end else begin
      unique case (state_q)
        opc_pkg::OPC_ST_HDR: begin
          o_strobe_mask      <= i_refresh_pending;
          o_strobe_mask_oe_n <= 1'b0;
          o_octal_io_oe_n    <= 1'b1;
        end
        opc_pkg::OPC_ST_LAT: begin
          o_strobe_mask      <= 1'b0;
          o_strobe_mask_oe_n <= ~is_read_op;
          o_octal_io_oe_n    <= 1'b1;
        end
        opc_pkg::OPC_ST_DATA: begin
          o_strobe_mask_oe_n <= ~is_read_op;
          o_octal_io_oe_n    <= ~is_read_op;
          if (edge_ok && is_read_op) begin
            o_octal_io    <= out_byte;
            o_strobe_mask <= ~o_strobe_mask;
          end
        end
        default: begin
          o_strobe_mask_oe_n <= 1'b1;
          o_octal_io_oe_n    <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write path

  assign wr_push     = edge_ok && state_q == opc_pkg::OPC_ST_DATA && op_q == opc_pkg::OPC_OP_WR &&
                       phase_q && !(mlo_q && i_strobe_mask);
  assign wr_in.valid = wr_push;
  assign wr_in.data  = {waddr_q, i_octal_io, lo_q, i_strobe_mask, mlo_q};

  always_ff @(posedge i_clk) begin
    if (rst) begin
      lo_q  <= 8'h00;
      mlo_q <= 1'b1;
    end else if (edge_ok && state_q == opc_pkg::OPC_ST_DATA && !phase_q) begin
      lo_q  <= i_octal_io;
      mlo_q <= i_strobe_mask;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst || (state_q == opc_pkg::OPC_ST_IDLE && !i_select_n && sel_q)) begin
      o_write_overrun <= 1'b0;
    end else if (wr_push && !wr_in.ready) begin
      o_write_overrun <= 1'b1;
    end
  end

  assign wr_out.ready = ~i_refresh_pending;
  assign mem_we       = (wr_out.valid && wr_out.ready) ? ~wr_out.data[1:0] : 2'h0;

  always_comb begin
    logic [7:0] b;
    b         = 8'h00;
    mem_wdata = 32'h00000000;
    for (int k = 0; k < 2; k++) begin
      b                     = wr_out.data[2 + k*8 +: 8];
      mem_wdata[k*16 +: 16] = {ecc_enc(b[7:4]), ecc_enc(b[3:0]), b ^ {6'h00, i_ecc_inject}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and ecc flag

  always_comb begin
    unique case (reg_sel(araw_q))
      opc_pkg::OPC_REG_ID:  regval = ID_VALUE;
      opc_pkg::OPC_REG_CFG: regval = cfg_q;
      opc_pkg::OPC_REG_ECC: regval = {ecc_q[15:10], o_ecc_event_flag, ecc_q[8:0]};
      default:              regval = 16'h0000;
    endcase
  end

  assign ecc_clr = edge_ok && state_q == opc_pkg::OPC_ST_DATA && op_q == opc_pkg::OPC_OP_RWR && phase_q &&
                   reg_sel(araw_q) == opc_pkg::OPC_REG_ECC && reg_hi_q[opc_pkg::ECC_CLR_BIT - 8];

  always_ff @(posedge i_clk) begin
    if (rst) begin
      reg_hi_q <= 8'h00;
      cfg_q    <= opc_pkg::CFG_RESET;
      ecc_q    <= opc_pkg::ECC_RESET;
    end else if (edge_ok && state_q == opc_pkg::OPC_ST_DATA && op_q == opc_pkg::OPC_OP_RWR) begin
      if (!phase_q) begin
        reg_hi_q <= i_octal_io;
      end else if (reg_sel(araw_q) == opc_pkg::OPC_REG_CFG) begin
        cfg_q <= {reg_hi_q, i_octal_io};
      end else if (reg_sel(araw_q) == opc_pkg::OPC_REG_ECC) begin
        ecc_q <= {reg_hi_q[7:2], 1'b0, reg_hi_q[0], i_octal_io};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_ecc_event_flag <= 1'b0;
    end else if (rvalid_q && rd_err) begin
      o_ecc_event_flag <= 1'b1;
    end else if (ecc_clr) begin
      o_ecc_event_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer and array

  opc_fifo #(.W(opc_pkg::FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_reset (rst),
    .in_s    (wr_in),
    .out_s   (wr_out)
  );

  opc_array #(.AW(AW), .DW(32)) u_array (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr (wr_out.data[opc_pkg::FIFO_W-1 -: AW]),
    .i_wdata (mem_wdata),
    .i_re    (rd_req_q),
    .i_raddr (waddr_q),
    .o_rdata (mem_rdata)
  );
endmodule

/* File: verification/opc_frontend_sva.sv */
// checker of the front end's pin behaviour
// assumes the front end's ports only; bound at the foot
`timescale 1ns/1ps
module opc_frontend_sva (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_hard_init_n,
  input wire logic       i_select_n,
  input wire logic       i_link_edge,
  input wire logic [7:0] o_octal_io,
  input wire logic       o_octal_io_oe_n,
  input wire logic       o_strobe_mask,
  input wire logic       o_strobe_mask_oe_n,
  input wire logic       o_ecc_event_flag,
  input wire logic       o_write_overrun
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  AST_HARD_INIT: assert property (!i_hard_init_n |=> o_octal_io_oe_n && o_strobe_mask_oe_n
    && o_octal_io == 8'h00 && !o_ecc_event_flag && !o_write_overrun) else $error("pins held in reset");
  AST_IDLE_FREE: assert property (i_select_n && $past(i_select_n)
    |=> o_octal_io_oe_n && o_strobe_mask_oe_n) else $error("pins driven while idle");
  AST_OE_SEL: assert property (!o_octal_io_oe_n |-> !$past(i_select_n)) else $error("drive without select");
  AST_HDR_FIRST: assert property ($fell(o_octal_io_oe_n) |-> !$past(i_select_n, 8)) else $error("early drive");
  AST_STB_ON: assert property (!o_octal_io_oe_n |-> !o_strobe_mask_oe_n) else $error("strobe not driven");
  AST_STB_TGL: assert property (i_link_edge && !o_octal_io_oe_n && !i_select_n
    |=> o_strobe_mask != $past(o_strobe_mask)) else $error("strobe did not toggle");
  AST_BYTE_HOLD: assert property (!o_octal_io_oe_n && !$past(i_link_edge)
    |-> $stable(o_octal_io)) else $error("read byte moved between edges");
  AST_FLAG_HOLD: assert property (o_ecc_event_flag && i_hard_init_n && i_select_n && $past(i_select_n)
    && $past(i_select_n, 2) |=> o_ecc_event_flag) else $error("ecc flag dropped");
endmodule
bind opc_frontend opc_frontend_sva opc_frontend_sva_i (.*);

/* File: verification/opc_host_model.sv */
// host controller model: select, edge pulses, bytes and write mask
// assumes the device takes a byte in a cycle where o_link_edge is high
`timescale 1ns/1ps
module opc_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_octal_io,
  output logic            o_select_n,
  output logic            o_link_edge,
  output logic      [7:0] o_host_io,
  output logic            o_host_mask
);
  logic [7:0] rx [$];
  initial begin
    o_select_n = 1'b1;
    o_link_edge = 1'b0;
    o_host_io = 8'h00;
    o_host_mask = 1'b0;
  end
  // one edge, bus then shows the inverse; edges four cycles apart
  task automatic link_edge(input logic [7:0] b, input logic m);
    @(posedge i_clk);
    o_host_io <= b;
    o_host_mask <= m;
    o_link_edge <= 1'b1;
    @(posedge i_clk);
    o_link_edge <= 1'b0;
    o_host_io <= ~b;
    repeat (2) @(posedge i_clk);
    rx.push_back(i_octal_io);
  endtask
  // falling select opens every transaction
  task automatic open_frame();
    @(posedge i_clk);
    o_select_n <= 1'b0;
  endtask
  task automatic close_frame();
    @(posedge i_clk);
    o_select_n <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

/* File: verification/opc_frontend_test.sv */
// testbench of the front end: register, memory, ecc and pattern reads
// assumes opc_host_model drives the link; pins resolved here
`timescale 1ns/1ps
module octal_psram_cmd_frontend_test;
  localparam logic [15:0] ID = 16'hc3a5;  // arbitrary identification value
  logic       i_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_hard_init_n = 1'b1;
  logic       i_refresh_pending = 1'b0;
  logic [1:0] i_ecc_inject = 2'h0;
  logic       i_select_n, i_link_edge, o_octal_io_oe_n, o_strobe_mask, o_strobe_mask_oe_n;
  logic       o_ecc_event_flag, o_write_overrun, i_strobe_mask, h_mask, oe_last;
  logic [7:0] i_octal_io, o_octal_io, h_io;
  logic [7:0] wd [16] = '{default: 8'h00};
  logic [15:0] wm = 16'h0000;
  logic [1:0] smk;
  int         fails = 0, n_tests = 0, cyc = 0;
  assign i_octal_io = o_octal_io_oe_n ? h_io : o_octal_io;
  assign i_strobe_mask = o_strobe_mask_oe_n ? h_mask : o_strobe_mask;
  opc_frontend #(.ID_VALUE(ID)) opc_frontend_i (.*);
  opc_host_model opc_host_model_i (.i_clk(i_clk), .i_octal_io(i_octal_io), .o_select_n(i_select_n),
    .o_link_edge(i_link_edge), .o_host_io(h_io), .o_host_mask(h_mask));
  initial forever #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tx(input logic [7:0] cmd, input logic [31:0] a, input int nl, input int nd);
    logic [7:0] hd [6];
    hd = '{cmd, 8'h00, a[31:24], a[23:16], a[15:8], a[7:0]};
    opc_host_model_i.open_frame();
    foreach (hd[i]) begin
      opc_host_model_i.link_edge(hd[i], 1'b0);
      if (i == 0) smk = {o_strobe_mask_oe_n, o_strobe_mask};
    end
    repeat (nl) opc_host_model_i.link_edge(8'h00, 1'b0);
    opc_host_model_i.rx.delete();
    for (int i = 0; i < nd; i++) opc_host_model_i.link_edge(wd[i], wm[i]);
    oe_last = o_octal_io_oe_n;
    opc_host_model_i.close_frame();
  endtask
  task automatic wreg(input logic [31:0] a, input logic [15:0] v);
    wd[0] = v[15:8];
    wd[1] = v[7:0];
    tx(8'h60, a, 0, 2);
  endtask
  function automatic logic [15:0] rw(input int k, input logic hi_first);
    logic [7:0] b0, b1;
    b0 = opc_host_model_i.rx[2*k];
    b1 = opc_host_model_i.rx[2*k+1];
    return hi_first ? {b0, b1} : {b1, b0};
  endfunction
  function automatic logic [7:0] trn(input int s, input int e);
    if (s == 1) return {8{opc_pkg::TRN_B_ALL[15-e]}};
    return {{4{opc_pkg::TRN_A_OTHER[15-e]}}, opc_pkg::TRN_A_LINE3[15-e], {3{opc_pkg::TRN_A_OTHER[15-e]}}};
  endfunction
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    chk("pins", 16'({o_octal_io_oe_n, o_strobe_mask_oe_n, o_ecc_event_flag}), 16'h0006);
    wreg(opc_pkg::SEL_CFG, 16'h0010);
    i_hard_init_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_hard_init_n <= 1'b1;
    tx(opc_pkg::CMD_RRD_A, opc_pkg::SEL_CFG, 6, 2);
    chk("cfg reset", rw(0, 1), opc_pkg::CFG_RESET);
    wreg(opc_pkg::SEL_CFG, 16'h0010);
    tx(opc_pkg::CMD_RRD_B, opc_pkg::SEL_CFG, 2, 2);
    chk("cfg", rw(0, 1), 16'h0010);
    tx(8'h11, 32'h0, 2, 2);
    chk("unknown oe", 16'(oe_last), 16'h0001);
    tx(opc_pkg::CMD_RRD_A, opc_pkg::SEL_ID, 2, 2);
    chk("id", rw(0, 1), ID);
    for (int i = 0; i < 4; i++) wd[i] = 8'h11 + 8'(i);
    tx(opc_pkg::CMD_WR_CONT, 32'h0, 2, 4);
    for (int i = 0; i < 4; i++) wd[i] = 8'ha1 + 8'(i);
    wm = 16'h0002;
    tx(opc_pkg::CMD_WR_WRAP, 32'h0, 2, 4);
    wm = 16'h0000;
    chk("overrun", 16'(o_write_overrun), 16'h0000);
    for (int j = 0; j < 2; j++) begin
      tx(j ? opc_pkg::CMD_RD_WRAP : opc_pkg::CMD_RD_CONT, 32'h0, 2, 4);
      chk("word0", rw(0, 0), 16'h12a1);
      chk("word1", rw(1, 0), 16'ha4a3);
    end
    i_refresh_pending <= 1'b1;
    tx(opc_pkg::CMD_RD_CONT, 32'h0, 4, 2);
    i_refresh_pending <= 1'b0;
    chk("refresh", rw(0, 0), 16'h12a1);
    chk("refresh ind", 16'(smk), 16'h0001);
    wreg(opc_pkg::SEL_CFG, 16'h0018);
    tx(opc_pkg::CMD_RD_CONT, 32'h0, 4, 2);
    chk("fixed", rw(0, 0), 16'h12a1);
    chk("no refresh ind", 16'(smk), 16'h0000);
    wreg(opc_pkg::SEL_CFG, 16'h0010);
    for (int k = 1; k < 4; k += 2) begin
      i_ecc_inject <= 2'(k);
      wd[0] = 8'h5a;
      wd[1] = 8'hc3;
      tx(opc_pkg::CMD_WR_CONT, 32'h8, 2, 2);
      i_ecc_inject <= 2'h0;
      tx(opc_pkg::CMD_RD_CONT, 32'h8, 2, 2);
      if (k == 1) chk("corrected", rw(0, 0), 16'hc35a);
      chk("ecc flag", 16'(o_ecc_event_flag), 16'h0001);
      wreg(opc_pkg::SEL_ECC, 16'h0200);
      chk("ecc clear", 16'(o_ecc_event_flag), 16'h0000);
    end
    for (int s = 0; s < 2; s++) begin
      tx(opc_pkg::CMD_TRAIN, 32'(s), 2, 16);
      for (int e = 0; e < 16; e++) chk("train", {8'h00, opc_host_model_i.rx[e]}, {8'h00, trn(s, e)});
    end
    test_done();
  end
endmodule
